//--- bbtc_core.sv
// Functional notes
// - Single conversion writes packed decimal of the unsigned source word.
// - Only result words are written; sources are never driven back.
// - Single source above 270F skips the write; result keeps old value.
// - Single source above 270F raises the error flag.
// - Faulty indirect operand raises error for every conversion.
// - Zero flag set when produced value is zero, else cleared.
// - Double conversion takes a 32-bit pair and writes eight digits.
// - Double source above 05F5E0FF skips the write of both words.
// - Double conversion raises error when result would pass 99999999.
// - Time source: seconds low byte, minutes high byte, hours next word.
// - Time conversion writes total seconds as decimal over two words.
// - Time conversion errors when source or result pair spans areas.
// - Time conversion errors on any nibble that is not decimal.
// - Time conversion errors when seconds or minutes exceed 59.
// - Nothing happens while the execution condition is false.
`timescale 1ns/1ns
`default_nettype none

module bbtc_core (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Issued instruction.
  input wire logic cmd_valid_i,
  input wire logic exec_cond_i,
  input wire bbtc_pkg::bbtc_req_t req_i,
  // Status.
  output logic busy_o,
  output logic done_o,
  output logic error_flag_o,
  output logic zero_result_flag_o,
  // Result words.
  output logic res_we_o,
  output logic res_dual_o,
  output bbtc_pkg::bbtc_res_t res_o
);
  import bbtc_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================

  // True when every nibble of a word is a decimal digit.
  function automatic logic bbtc_is_bcd(input logic [15:0] word);
    bbtc_is_bcd = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (word[i*4 +: 4] > 4'h9) begin
        bbtc_is_bcd = 1'b0;
      end
    end
  endfunction

  // Four packed digits to binary; callers check validity first.
  function automatic logic [13:0] bbtc_bcd_to_bin(input logic [15:0] word);
    logic [13:0] acc;
    acc = 14'h0000;
    for (int i = 3; i >= 0; i--) begin
      acc = 14'((acc * 14'hA) + {10'h000, word[i*4 +: 4]});
    end
    bbtc_bcd_to_bin = acc;
  endfunction

  typedef enum logic {BBTC_IDLE, BBTC_CONV} bbtc_state_t;

  bbtc_state_t state;
  bbtc_op_t op_q;
  logic take;
  logic req_err;
  logic start;
  logic conv_done;
  logic [31:0] conv_bcd;
  logic [31:0] conv_value;
  logic [7:0] sec_field;
  logic [7:0] min_field;
  logic [25:0] total_sec;

  // ==========================================================================
  // Request checks
  // ==========================================================================

  // A request is only taken with a true execution condition.
  assign take = cmd_valid_i && exec_cond_i && (state == BBTC_IDLE);

  // Time fields: seconds in the low byte, minutes in the high byte.
  assign sec_field = req_i.src_lo[BBTC_SEC_LSB +: 8];
  assign min_field = req_i.src_lo[BBTC_MIN_LSB +: 8];

  // Hours arrive as four digits in the following word.
  assign total_sec =
    26'(bbtc_bcd_to_bin(req_i.src_hi)) * BBTC_SEC_PER_HOUR +
    26'(bbtc_bcd_to_bin({8'h00, min_field})) * BBTC_SEC_PER_MIN +
    26'(bbtc_bcd_to_bin({8'h00, sec_field}));

  // Error detection per operation, all found before any write.
  always_comb begin
    req_err = req_i.indirect_fault;
    case (req_i.op)
      BBTC_OP_SINGLE: begin
        if (req_i.src_lo > BBTC_SINGLE_MAX) begin
          req_err = 1'b1;
        end
      end
      BBTC_OP_DOUBLE: begin
        // The issuer keeps the pairs in one area, so no split check.
        if ({req_i.src_hi, req_i.src_lo} > BBTC_DOUBLE_MAX) begin
          req_err = 1'b1;
        end
      end
      BBTC_OP_HMS: begin
        if (req_i.src_area_split || req_i.dst_area_split) begin
          req_err = 1'b1;
        end
        if (!bbtc_is_bcd(req_i.src_lo) || !bbtc_is_bcd(req_i.src_hi)) begin
          req_err = 1'b1;
        end
        if (sec_field > BBTC_FIELD_MAX || min_field > BBTC_FIELD_MAX) begin
          req_err = 1'b1;
        end
      end
      default: begin
        req_err = 1'b1;
      end
    endcase
  end

  assign start = take && !req_err;

  // Binary value fed to the shared converter; high word is the upper half.
  always_comb begin
    case (req_i.op)
      BBTC_OP_SINGLE: conv_value = {16'h0000, req_i.src_lo};
      BBTC_OP_DOUBLE: conv_value = {req_i.src_hi, req_i.src_lo};
      BBTC_OP_HMS: conv_value = {6'h00, total_sec};
      default: conv_value = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // Converter
  // ==========================================================================

  // One shared iterative converter; slower than a flat network but small.
  bbtc_dabble u_dabble (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(start),
    .value_i(conv_value),
    .done_o(conv_done),
    .bcd_o(conv_bcd)
  );

  // ==========================================================================
  // Control
  // ==========================================================================

  // Sequencing; a request arriving while busy is ignored.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= BBTC_IDLE;
      op_q <= BBTC_OP_SINGLE;
      busy_o <= 1'b0;
    end else begin
      case (state)
        BBTC_IDLE: begin
          if (start) begin
            state <= BBTC_CONV;
            op_q <= req_i.op;
            busy_o <= 1'b1;
          end
        end
        BBTC_CONV: begin
          if (conv_done) begin
            state <= BBTC_IDLE;
            busy_o <= 1'b0;
          end
        end
        default: begin
          state <= BBTC_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Flags and result words
  // ==========================================================================

  // Flags hold until the next executed conversion finishes.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_o <= 1'b0;
      error_flag_o <= 1'b0;
      zero_result_flag_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (take && req_err) begin
        done_o <= 1'b1;
        error_flag_o <= 1'b1;
        // No value is produced, so the zero flag is cleared.
        zero_result_flag_o <= 1'b0;
      end else if (state == BBTC_CONV && conv_done) begin
        done_o <= 1'b1;
        error_flag_o <= 1'b0;
        if (op_q == BBTC_OP_SINGLE) begin
          zero_result_flag_o <= (conv_bcd[15:0] == 16'h0000);
        end else begin
          zero_result_flag_o <= (conv_bcd == 32'h00000000);
        end
      end
    end
  end

  // Only the result pair is ever written; the sources have no path back.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      res_we_o <= 1'b0;
      res_dual_o <= 1'b0;
      res_o <= {BBTC_RES_RESET, BBTC_RES_RESET};
    end else begin
      res_we_o <= 1'b0;
      // Error path never reaches here, so results stay put.
      if (state == BBTC_CONV && conv_done) begin
        res_we_o <= 1'b1;
        res_o.res_lo <= conv_bcd[15:0];
        if (op_q != BBTC_OP_SINGLE) begin
          res_dual_o <= 1'b1;
          res_o.res_hi <= conv_bcd[31:16];
        end else begin
          res_dual_o <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- bbtc_pkg.sv
`default_nettype none

package bbtc_pkg;

  // ==========================================================================
  // Operation codes and carriers
  // ==========================================================================

  // Conversion selected by an issued instruction.
  typedef enum logic [1:0] {
    BBTC_OP_SINGLE,
    BBTC_OP_DOUBLE,
    BBTC_OP_HMS
  } bbtc_op_t;

  // One issued conversion with its operands and addressing status.
  typedef struct packed {
    bbtc_op_t op;
    logic [15:0] src_lo;
    logic [15:0] src_hi;
    logic indirect_fault;
    logic src_area_split;
    logic dst_area_split;
  } bbtc_req_t;

  // Result word pair offered to the destination.
  typedef struct packed {
    logic [15:0] res_lo;
    logic [15:0] res_hi;
  } bbtc_res_t;

  // ==========================================================================
  // Limits, field positions and timing
  // ==========================================================================

  localparam logic [15:0] BBTC_SINGLE_MAX = 16'h270F;
  localparam logic [31:0] BBTC_DOUBLE_MAX = 32'h05F5E0FF;
  localparam logic [7:0] BBTC_FIELD_MAX = 8'h59;
  localparam int BBTC_SEC_LSB = 0;
  localparam int BBTC_MIN_LSB = 8;
  localparam logic [25:0] BBTC_SEC_PER_HOUR = 26'hE10;
  localparam logic [25:0] BBTC_SEC_PER_MIN = 26'h3C;
  localparam logic [5:0] BBTC_DABBLE_LAST = 6'h1F;
  localparam logic [15:0] BBTC_RES_RESET = 16'h0000;

endpackage

`default_nettype wire

//--- bbtc_dabble.sv
`timescale 1ns/1ns
`default_nettype none

module bbtc_dabble (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Start strobe with the binary value.
  input wire logic start_i,
  input wire logic [31:0] value_i,
  // Result.
  output logic done_o,
  output logic [31:0] bcd_o
);
  import bbtc_pkg::*;

  // ==========================================================================
  // Digit adjustment
  // ==========================================================================

  // Adds three to a digit of five or more so the next shift carries right.
  function automatic logic [3:0] bbtc_adjust(input logic [3:0] digit);
    bbtc_adjust = (digit >= 4'h5) ? digit + 4'h3 : digit;
  endfunction

  logic [31:0] shift;
  logic [31:0] next_bcd;
  logic [5:0] cnt;
  logic run;

  // One shift per clock keeps the adder tree to eight small digit adders.
  always_comb begin
    next_bcd = '0;
    for (int i = 0; i < 8; i++) begin
      next_bcd[i*4 +: 4] = bbtc_adjust(bcd_o[i*4 +: 4]);
    end
    next_bcd = {next_bcd[30:0], shift[31]};
  end

  // ==========================================================================
  // Sequencing
  // ==========================================================================

  // Runs exactly thirty-two shifts after a start.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run <= 1'b0;
      cnt <= 6'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        run <= 1'b1;
        cnt <= 6'h00;
      end else if (run) begin
        cnt <= cnt + 6'h01;
        if (cnt == BBTC_DABBLE_LAST) begin
          run <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  // Data path: load on start, then shift while running.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift <= 32'h00000000;
      bcd_o <= 32'h00000000;
    end else if (start_i) begin
      shift <= value_i;
      bcd_o <= 32'h00000000;
    end else if (run) begin
      shift <= {shift[30:0], 1'b0};
      bcd_o <= next_bcd;
    end
  end

endmodule
`default_nettype wire

//--- bbtc_core_props.sv
`timescale 1ns/1ns
`default_nettype none

module bbtc_core_props (
  // Clock, reset and request.
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic cmd_valid_i,
  input wire logic exec_cond_i,
  input wire bbtc_pkg::bbtc_req_t req_i,
  // Observed outputs.
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic error_flag_o,
  input wire logic zero_result_flag_o,
  input wire logic res_we_o,
  input wire logic res_dual_o,
  input wire bbtc_pkg::bbtc_res_t res_o
);
  import bbtc_pkg::*;

  // ==========
  // Helpers
  // ==========
  // A request counts only when idle and enabled.
  logic take;
  logic ok;
  assign take = cmd_valid_i && exec_cond_i && !busy_o;
  assign ok = take && !req_i.indirect_fault &&
    ((req_i.op == BBTC_OP_SINGLE && req_i.src_lo <= BBTC_SINGLE_MAX) ||
     (req_i.op == BBTC_OP_DOUBLE &&
      {req_i.src_hi, req_i.src_lo} <= BBTC_DOUBLE_MAX));

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // A refusal answers at once and must not write.
  sequence s_err;
    done_o && error_flag_o && !res_we_o;
  endsequence
  // A good conversion is busy for the first eight cycles, then writes exactly on the 34th edge.
  sequence s_run;
    busy_o [*8] ##26 (done_o && res_we_o && !error_flag_o);
  endsequence

  // ==========
  // Assertions
  // ==========
  a_single_over: assert property (
    take && req_i.op == BBTC_OP_SINGLE && req_i.src_lo > BBTC_SINGLE_MAX
    |=> s_err) else $error("single overflow not refused");
  a_double_over: assert property (
    take && req_i.op == BBTC_OP_DOUBLE &&
    {req_i.src_hi, req_i.src_lo} > BBTC_DOUBLE_MAX
    |=> s_err) else $error("double overflow not refused");
  a_hms_split: assert property (
    take && req_i.op == BBTC_OP_HMS &&
    (req_i.src_area_split || req_i.dst_area_split)
    |=> s_err) else $error("split pair not refused");
  a_fault_err: assert property (
    take && req_i.indirect_fault |=> s_err)
    else $error("indirect fault not refused");
  a_good_run: assert property (
    ok |=> s_run) else $error("good conversion timing wrong");
  a_no_exec: assert property (
    cmd_valid_i && !exec_cond_i && !busy_o |=> !done_o)
    else $error("disabled request answered");
  a_zero_flag: assert property (
    done_o && res_we_o |-> zero_result_flag_o == (res_dual_o ?
    ({res_o.res_hi, res_o.res_lo} == 32'h0) : (res_o.res_lo == 16'h0)))
    else $error("zero flag wrong");
  a_write_only: assert property (
    $changed(res_o) |-> res_we_o) else $error("result moved without write");
  a_high_hold: assert property (
    res_we_o && !res_dual_o |-> $stable(res_o.res_hi))
    else $error("single write touched high word");
endmodule

`default_nettype wire

//--- test_binary_bcd_time_converter.sv
`timescale 1ns/1ns
`default_nettype none

module test_binary_bcd_time_converter;
  import bbtc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic exec_cond_i = 1'b0;
  bbtc_req_t req_i = '0;
  logic busy_o, done_o, error_flag_o, zero_result_flag_o, res_we_o, res_dual_o;
  bbtc_res_t res_o;
  int fails = 0;
  int compares = 0;

  // Free-running 125 MHz clock.
  always #4 sys_clk_i = ~sys_clk_i;

  bbtc_core i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .cmd_valid_i(cmd_valid_i), .exec_cond_i(exec_cond_i), .req_i(req_i),
    .busy_o(busy_o), .done_o(done_o), .error_flag_o(error_flag_o),
    .zero_result_flag_o(zero_result_flag_o), .res_we_o(res_we_o),
    .res_dual_o(res_dual_o), .res_o(res_o));

  // ==========
  // Shared tasks
  // ==========
  task check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task results;
    $display("Compares %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One request; x holds the expected decimal {high, low} words.
  task conv(input bbtc_op_t op, input logic [15:0] lo, hi,
    input logic [2:0] f, input logic e, input logic [31:0] x);
    bbtc_res_t old;
    int n;
    logic s;
    logic z;
    logic [31:0] want;
    old = res_o;
    s = (op == BBTC_OP_SINGLE);
    req_i = {op, lo, hi, f};
    cmd_valid_i = 1'b1;
    exec_cond_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    check("busy", busy_o, !e);
    n = 1;
    while (done_o !== 1'b1 && n < 40) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check("latency", n, e ? 1 : 34);
    check("error", error_flag_o, e);
    check("write", res_we_o, !e);
    // A refused request leaves both words; a single one keeps the high word.
    want = {old.res_hi, old.res_lo};
    if (!e) begin
      want = s ? {old.res_hi, x[15:0]} : x;
    end
    z = s ? (x[15:0] == 16'h0000) : (x == 32'h00000000);
    check("result", {res_o.res_hi, res_o.res_lo}, want);
    if (!e) begin
      check("dual", res_dual_o, !s);
    end
    check("zero", zero_result_flag_o, !e && z);
    @(posedge sys_clk_i);
    #1;
    check("pulse", done_o, 1'b0);
    check("busy end", busy_o, 1'b0);
  endtask

  // ==========
  // Scenarios
  // ==========
  task t_single;
    conv(BBTC_OP_SINGLE, 16'h270F, 16'hABCD, 3'h0, 1'b0, 32'h9999);
    conv(BBTC_OP_SINGLE, 16'h2710, 16'h0000, 3'h0, 1'b1, 32'h0);
    conv(BBTC_OP_SINGLE, 16'h0000, 16'h0000, 3'h0, 1'b0, 32'h0);
    $display("single conversion test over");
  endtask

  task t_double;
    // Both pairs are kept inside one area, as the issuer must.
    conv(BBTC_OP_DOUBLE, 16'hE0FF, 16'h05F5, 3'h0, 1'b0,
      32'h99999999);
    conv(BBTC_OP_DOUBLE, 16'h614E, 16'h00BC, 3'h0, 1'b0,
      32'h12345678);
    conv(BBTC_OP_DOUBLE, 16'hE100, 16'h05F5, 3'h0, 1'b1, 32'h0);
    $display("double conversion test over");
  endtask

  task t_hms;
    conv(BBTC_OP_HMS, 16'h0101, 16'h0001, 3'h0, 1'b0, 32'h3661);
    conv(BBTC_OP_HMS, 16'h5959, 16'h9999, 3'h0, 1'b0,
      32'h35999999);
    conv(BBTC_OP_HMS, 16'h0060, 16'h0000, 3'h0, 1'b1, 32'h0);
    conv(BBTC_OP_HMS, 16'h6000, 16'h0000, 3'h0, 1'b1, 32'h0);
    conv(BBTC_OP_HMS, 16'h000A, 16'h0000, 3'h0, 1'b1, 32'h0);
    conv(BBTC_OP_HMS, 16'h0000, 16'h00A0, 3'h0, 1'b1, 32'h0);
    conv(BBTC_OP_HMS, 16'h0001, 16'h0000, 3'h2, 1'b1, 32'h0);
    conv(BBTC_OP_HMS, 16'h0001, 16'h0000, 3'h1, 1'b1, 32'h0);
    conv(BBTC_OP_HMS, 16'h0000, 16'h0000, 3'h0, 1'b0, 32'h0);
    $display("time conversion test over");
  endtask

  task t_fault;
    for (int k = 0; k < 3; k++) begin
      conv(bbtc_op_t'(k), 16'h0001, 16'h0000, 3'h4, 1'b1, 32'h0);
    end
    $display("indirect fault test over");
  endtask

  // A disabled request must leave no trace at all.
  task t_noexec;
    bbtc_res_t old;
    logic seen;
    logic err;
    old = res_o;
    err = error_flag_o;
    seen = 1'b0;
    req_i = {BBTC_OP_SINGLE, 16'h0001, 16'h0000, 3'h0};
    exec_cond_i = 1'b0;
    cmd_valid_i = 1'b1;
    repeat (40) begin
      @(posedge sys_clk_i);
      #1;
      seen = seen | done_o;
    end
    cmd_valid_i = 1'b0;
    check("idle done", seen, 1'b0);
    check("idle result", res_o, old);
    check("idle error", error_flag_o, err);
    $display("disabled request test over");
  endtask

  // Reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b1;
    t_single;
    t_double;
    t_hms;
    t_fault;
    t_noexec;
    results;
  end

  // About 310 cycles are needed; 3000 leaves ample margin.
  initial begin
    #24000;
    fails++;
    results;
  end
endmodule

bind bbtc_core bbtc_core_props i_props (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
  .exec_cond_i(exec_cond_i), .req_i(req_i), .busy_o(busy_o),
  .done_o(done_o), .error_flag_o(error_flag_o),
  .zero_result_flag_o(zero_result_flag_o), .res_we_o(res_we_o),
  .res_dual_o(res_dual_o), .res_o(res_o));

`default_nettype wire
